/* File: verilog/smb_dev.sv */
// Purpose: device end of the serial register port
// Assumes: scl and sda come from another domain; register file answers rd_data combinationally
// Notes: only one data byte is returned per read; third and later write bytes are refused
`timescale 1ns/10ps
`include "smb_defines.svh"
// What this block does
// - strap enable high selects fixed address
// - otherwise select strap picks one of two
// - address fixed at eighth rise of match
// - eight data bits plus one ack bit
// - sda moves with scl low; rise means stop
// - master ends write with stop
// - master nacks read, then stops
// - direction held until new start
// - writes carry one or two bytes; reads one
// - first byte loads pointer, second writes register
// - read returns register at current pointer
// - pointer-only write then separate read
// - combined pointer set and read supported
// - repeated start begins a new address byte
// - release bus after idle timeout unless disabled
module smb_dev #(
  parameter int TIMEOUT_CYC = `SMB_TIMEOUT_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  smb_if.dev bus,
  input wire logic address_strap_enable,
  input wire logic address_strap_select,
  input wire logic bus_timeout_disable,
  input wire logic [7:0] rd_data,
  output logic [7:0] reg_index_ff,
  output logic wr_valid_ff,
  output logic [7:0] wr_data_ff,
  output logic [6:0] bus_addr_ff,
  output logic addr_locked_ff
);
  localparam int TW = $clog2(TIMEOUT_CYC + 1);

  logic [2:0] scl_sync_ff;
  logic [2:0] sda_sync_ff;
  logic scl_lvl_ff;
  logic sda_lvl_ff;
  logic [2:0] ens_sync_ff;
  logic [2:0] sel_sync_ff;
  logic [1:0] strap_wait_ff;
  logic strap_done_ff;
  logic [6:0] strap_addr_ff;
  logic [6:0] nxt_strap_addr;
  smb_pkg::smb_dev_state_t state_ff;
  smb_pkg::smb_dev_state_t nxt_state;
  logic [3:0] cnt_ff;
  logic [3:0] nxt_cnt;
  logic [7:0] shift_ff;
  logic [7:0] nxt_shift;
  logic is_read_ff;
  logic nxt_is_read;
  logic match_ff;
  logic nxt_match;
  logic [1:0] byte_no_ff;
  logic [1:0] nxt_byte_no;
  logic sda_oe_ff;
  logic nxt_sda_oe;
  logic [7:0] nxt_reg_index;
  logic nxt_wr_valid;
  logic [7:0] nxt_wr_data;
  logic [6:0] nxt_bus_addr;
  logic nxt_addr_locked;
  logic [TW-1:0] tmo_cnt_ff;
  logic [TW-1:0] nxt_tmo_cnt;
  logic sda_o_ff;

  // filtered line levels and their edges
  wire scl_agree = scl_sync_ff[1] == scl_sync_ff[2];
  wire sda_agree = sda_sync_ff[1] == sda_sync_ff[2];
  wire scl_rise = scl_agree & scl_sync_ff[2] & ~scl_lvl_ff;
  wire scl_fall = scl_agree & ~scl_sync_ff[2] & scl_lvl_ff;
  wire sda_rise = sda_agree & sda_sync_ff[2] & ~sda_lvl_ff;
  wire sda_fall = sda_agree & ~sda_sync_ff[2] & sda_lvl_ff;
  wire start_cond = sda_fall & scl_lvl_ff & ~scl_fall;
  wire stop_cond = sda_rise & scl_lvl_ff & ~scl_fall;
  wire sda_bit = sda_sync_ff[2];
  wire tmo_hit = ~bus_timeout_disable & (tmo_cnt_ff == TW'(TIMEOUT_CYC - 1));
  wire [6:0] cmp_addr = addr_locked_ff ? bus_addr_ff : strap_addr_ff;
  wire addr_match = strap_done_ff & (shift_ff[6:0] == cmp_addr);
  wire strap_ok = (ens_sync_ff[1] == ens_sync_ff[2]) & (sel_sync_ff[1] == sel_sync_ff[2]);

  // strap decode
  always_comb begin
    if (ens_sync_ff[2]) begin
      nxt_strap_addr = `SMB_ADDR_FIXED;
    end else if (sel_sync_ff[2]) begin
      nxt_strap_addr = `SMB_ADDR_SEL_HIGH;
    end else begin
      nxt_strap_addr = `SMB_ADDR_SEL_LOW;
    end
  end

  // idle-time watchdog
  always_comb begin
    if (state_ff == smb_pkg::D_IDLE || scl_rise || scl_fall) begin
      nxt_tmo_cnt = '0;
    end else if (tmo_hit) begin
      nxt_tmo_cnt = '0;
    end else begin
      nxt_tmo_cnt = tmo_cnt_ff + TW'(1);
    end
  end

  // byte engine
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_shift = shift_ff;
    nxt_is_read = is_read_ff;
    nxt_match = match_ff;
    nxt_byte_no = byte_no_ff;
    nxt_sda_oe = sda_oe_ff;
    nxt_reg_index = reg_index_ff;
    nxt_wr_valid = 1'b0;
    nxt_wr_data = wr_data_ff;
    nxt_bus_addr = bus_addr_ff;
    nxt_addr_locked = addr_locked_ff;
    if (start_cond) begin
      nxt_state = smb_pkg::D_ADDR;
      nxt_cnt = 4'h0;
      nxt_byte_no = 2'h0;
      nxt_sda_oe = 1'b0;
    end else if (stop_cond || tmo_hit) begin
      nxt_state = smb_pkg::D_IDLE;
      nxt_sda_oe = 1'b0;
    end else begin
      case (state_ff)
        smb_pkg::D_ADDR: begin
          if (scl_rise) begin
            nxt_shift = {shift_ff[6:0], sda_bit};
            nxt_cnt = cnt_ff + 4'h1;
            if (cnt_ff == 4'h7) begin
              nxt_match = addr_match;
              nxt_is_read = sda_bit;
              if (addr_match && !addr_locked_ff) begin
                nxt_addr_locked = 1'b1;
                nxt_bus_addr = cmp_addr;
              end
            end
          end else if (scl_fall && cnt_ff == `SMB_BITS_PER_BYTE) begin
            if (match_ff) begin
              nxt_sda_oe = 1'b1;
              nxt_state = smb_pkg::D_ACK;
            end else begin
              nxt_state = smb_pkg::D_IDLE;
            end
          end
        end
        smb_pkg::D_ACK: begin
          if (scl_fall) begin
            nxt_cnt = 4'h0;
            if (is_read_ff == `SMB_DIR_READ) begin
              nxt_shift = rd_data;
              nxt_sda_oe = ~rd_data[7];
              nxt_state = smb_pkg::D_RD;
            end else begin
              nxt_sda_oe = 1'b0;
              nxt_state = smb_pkg::D_WR;
            end
          end
        end
        smb_pkg::D_WR: begin
          if (scl_rise) begin
            nxt_shift = {shift_ff[6:0], sda_bit};
            nxt_cnt = cnt_ff + 4'h1;
          end else if (scl_fall && cnt_ff == `SMB_BITS_PER_BYTE) begin
            nxt_state = smb_pkg::D_ACK;
            nxt_sda_oe = 1'b1;
            nxt_byte_no = byte_no_ff + 2'h1;
            if (byte_no_ff == 2'h0) begin
              nxt_reg_index = shift_ff;
            end else if (byte_no_ff == 2'h1) begin
              nxt_wr_valid = 1'b1;
              nxt_wr_data = shift_ff;
            end else begin
              nxt_sda_oe = 1'b0;
              nxt_byte_no = byte_no_ff;
              nxt_state = smb_pkg::D_IDLE;
            end
          end
        end
        smb_pkg::D_RD: begin
          if (scl_fall) begin
            nxt_cnt = cnt_ff + 4'h1;
            if (cnt_ff == 4'h7) begin
              nxt_sda_oe = 1'b0;
              nxt_state = smb_pkg::D_RD_ACK;
            end else begin
              nxt_shift = {shift_ff[6:0], 1'b0};
              nxt_sda_oe = ~shift_ff[6];
            end
          end
        end
        smb_pkg::D_RD_ACK: begin
          if (scl_rise) begin
            nxt_state = smb_pkg::D_IDLE;
          end
        end
        default: begin
          nxt_sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_sync_ff <= 3'h7;
      sda_sync_ff <= 3'h7;
      scl_lvl_ff <= 1'b1;
      sda_lvl_ff <= 1'b1;
      ens_sync_ff <= 3'h0;
      sel_sync_ff <= 3'h0;
    end else begin
      scl_sync_ff <= {scl_sync_ff[1:0], bus.scl};
      sda_sync_ff <= {sda_sync_ff[1:0], bus.sda};
      scl_lvl_ff <= scl_agree ? scl_sync_ff[2] : scl_lvl_ff;
      sda_lvl_ff <= sda_agree ? sda_sync_ff[2] : sda_lvl_ff;
      ens_sync_ff <= {ens_sync_ff[1:0], address_strap_enable};
      sel_sync_ff <= {sel_sync_ff[1:0], address_strap_select};
    end
  end

  // straps taken once after reset release
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      strap_wait_ff <= 2'h0;
      strap_done_ff <= 1'b0;
      strap_addr_ff <= `SMB_ADDR_SEL_LOW;
    end else if (!strap_done_ff) begin
      strap_wait_ff <= (strap_wait_ff == 2'h3) ? strap_wait_ff : strap_wait_ff + 2'h1;
      if (strap_wait_ff == 2'h3 && strap_ok) begin
        strap_done_ff <= 1'b1;
        strap_addr_ff <= nxt_strap_addr;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= smb_pkg::D_IDLE;
      cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      is_read_ff <= 1'b0;
      match_ff <= 1'b0;
      byte_no_ff <= 2'h0;
      sda_oe_ff <= 1'b0;
      sda_o_ff <= 1'b0;
      tmo_cnt_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      shift_ff <= nxt_shift;
      is_read_ff <= nxt_is_read;
      match_ff <= nxt_match;
      byte_no_ff <= nxt_byte_no;
      sda_oe_ff <= nxt_sda_oe;
      sda_o_ff <= 1'b0;
      tmo_cnt_ff <= nxt_tmo_cnt;
    end
  end

  // pointer survives between operations
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_index_ff <= 8'h00;
      wr_valid_ff <= 1'b0;
      wr_data_ff <= 8'h00;
      bus_addr_ff <= `SMB_ADDR_SEL_LOW;
      addr_locked_ff <= 1'b0;
    end else begin
      reg_index_ff <= nxt_reg_index;
      wr_valid_ff <= nxt_wr_valid;
      wr_data_ff <= nxt_wr_data;
      bus_addr_ff <= nxt_bus_addr;
      addr_locked_ff <= nxt_addr_locked;
    end
  end

  assign bus.sda_dev_o = sda_o_ff;
  assign bus.sda_dev_oe = sda_oe_ff;
endmodule : smb_dev

/* File: verilog/smb_defines.svh */
// Purpose: constants shared by both ends of the serial register port
// Assumes: 40 MHz system clock on both ends
// Notes: addresses are 7-bit bus addresses without the direction bit
`ifndef SMB_DEFINES_SVH
`define SMB_DEFINES_SVH
`define SMB_ADDR_FIXED 7'h2e
`define SMB_ADDR_SEL_LOW 7'h2c
`define SMB_ADDR_SEL_HIGH 7'h2d
`define SMB_CLK_HZ 40000000
`define SMB_TIMEOUT_MS 35
`define SMB_TIMEOUT_CYC (`SMB_CLK_HZ / 1000 * `SMB_TIMEOUT_MS)
`define SMB_SCL_HZ 100000
`define SMB_QTR_CYC (`SMB_CLK_HZ / `SMB_SCL_HZ / 4)
`define SMB_DIR_READ 1'b1
`define SMB_DIR_WRITE 1'b0
`define SMB_BITS_PER_BYTE 4'h8
`endif

/* File: verilog/smb_pkg.sv */
// Purpose: types shared by both ends of the serial register port
// Assumes: nothing beyond the defines header
// Notes: state and command encodings are left to the tools
package smb_pkg;
  typedef enum logic [2:0] {D_IDLE, D_ADDR, D_ACK, D_WR, D_RD, D_RD_ACK} smb_dev_state_t;
  typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} smb_host_state_t;
  typedef enum logic [2:0] {S_ADDRW, S_PTR, S_DATA, S_ADDRR, S_READ} smb_step_t;
  typedef enum logic [1:0] {C_SEND_PTR, C_WRITE, C_RECEIVE, C_READ_BYTE} smb_cmd_t;
endpackage : smb_pkg

/* File: verilog/smb_if.sv */
// Purpose: open-drain two-wire bus joining the host and device ends
// Assumes: pull-ups on both wires
// Notes: a wire reads low whenever any end enables a low drive
`timescale 1ns/10ps
interface smb_if;
  logic scl_host_o;
  logic scl_host_oe;
  logic sda_host_o;
  logic sda_host_oe;
  logic sda_dev_o;
  logic sda_dev_oe;
  logic scl;
  logic sda;
  // wired-and of the driving ends with pull-up; only the host drives scl, both ends drive sda
  assign scl = ~(scl_host_oe & ~scl_host_o);
  assign sda = ~((sda_host_oe & ~sda_host_o) | (sda_dev_oe & ~sda_dev_o));
  modport dev (input scl, input sda, output sda_dev_o, output sda_dev_oe);
  modport host (input scl, input sda, output scl_host_o, output scl_host_oe, output sda_host_o, output sda_host_oe);
endinterface : smb_if

/* File: verilog/smb_host.sv */
// Purpose: host end that drives clock and runs one transaction per command
// Assumes: device never stretches the clock
// Notes: clock made by dividing clk; one bit is four quarter periods
`timescale 1ns/10ps
`include "smb_defines.svh"
module smb_host #(
  parameter int QTR_CYC = `SMB_QTR_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  smb_if.host bus,
  input wire logic cmd_valid,
  input wire smb_pkg::smb_cmd_t cmd_kind,
  input wire logic [6:0] cmd_addr,
  input wire logic [7:0] cmd_ptr,
  input wire logic [7:0] cmd_data,
  output logic cmd_ready_ff,
  output logic done_ff,
  output logic nack_ff,
  output logic [7:0] rd_data_ff
);
  localparam int QW = $clog2(QTR_CYC + 1);

  logic [QW-1:0] q_cnt_ff;
  logic [1:0] phase_ff;
  logic [2:0] sda_sync_ff;
  logic sda_lvl_ff;
  smb_pkg::smb_host_state_t state_ff;
  smb_pkg::smb_step_t step_ff;
  smb_pkg::smb_cmd_t kind_ff;
  logic [6:0] addr_ff;
  logic [7:0] ptr_ff;
  logic [7:0] data_ff;
  logic [8:0] tx_ff;
  logic [8:0] rx_ff;
  logic [3:0] bit_ff;
  logic scl_oe_ff;
  logic sda_oe_ff;
  logic zero_ff;

  wire tick = q_cnt_ff == QW'(QTR_CYC - 1);
  wire byte_end = (state_ff == smb_pkg::H_BIT) & tick & (phase_ff == 2'h3) & (bit_ff == `SMB_BITS_PER_BYTE);
  wire got_nack = rx_ff[0];
  wire is_recv = cmd_kind == smb_pkg::C_RECEIVE;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sda_sync_ff <= 3'h7;
      sda_lvl_ff <= 1'b1;
      q_cnt_ff <= '0;
      zero_ff <= 1'b0;
    end else begin
      sda_sync_ff <= {sda_sync_ff[1:0], bus.sda};
      sda_lvl_ff <= (sda_sync_ff[1] == sda_sync_ff[2]) ? sda_sync_ff[2] : sda_lvl_ff;
      q_cnt_ff <= (tick || state_ff == smb_pkg::H_IDLE) ? '0 : q_cnt_ff + QW'(1);
      zero_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= smb_pkg::H_IDLE;
      step_ff <= smb_pkg::S_ADDRW;
      kind_ff <= smb_pkg::C_SEND_PTR;
      addr_ff <= 7'h00;
      ptr_ff <= 8'h00;
      data_ff <= 8'h00;
      tx_ff <= 9'h1ff;
      rx_ff <= 9'h000;
      bit_ff <= 4'h0;
      phase_ff <= 2'h0;
      scl_oe_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      cmd_ready_ff <= 1'b1;
      done_ff <= 1'b0;
      nack_ff <= 1'b0;
      rd_data_ff <= 8'h00;
    end else begin
      done_ff <= 1'b0;
      case (state_ff)
        smb_pkg::H_IDLE: begin
          phase_ff <= 2'h0;
          if (cmd_valid) begin
            cmd_ready_ff <= 1'b0;
            nack_ff <= 1'b0;
            kind_ff <= cmd_kind;
            addr_ff <= cmd_addr;
            ptr_ff <= cmd_ptr;
            data_ff <= cmd_data;
            step_ff <= is_recv ? smb_pkg::S_ADDRR : smb_pkg::S_ADDRW;
            tx_ff <= {cmd_addr, is_recv ? `SMB_DIR_READ : `SMB_DIR_WRITE, 1'b1};
            state_ff <= smb_pkg::H_START;
          end
        end
        smb_pkg::H_START: begin
          if (tick) begin
            phase_ff <= phase_ff + 2'h1;
            case (phase_ff)
              2'h0: sda_oe_ff <= 1'b0;
              2'h1: scl_oe_ff <= 1'b0;
              2'h2: sda_oe_ff <= 1'b1;
              default: begin
                scl_oe_ff <= 1'b1;
                bit_ff <= 4'h0;
                state_ff <= smb_pkg::H_BIT;
              end
            endcase
          end
        end
        smb_pkg::H_BIT: begin
          if (tick) begin
            phase_ff <= phase_ff + 2'h1;
            case (phase_ff)
              2'h0: sda_oe_ff <= ~tx_ff[8];
              2'h1: scl_oe_ff <= 1'b0;
              2'h2: rx_ff <= {rx_ff[7:0], sda_lvl_ff};
              default: begin
                scl_oe_ff <= 1'b1;
                tx_ff <= {tx_ff[7:0], 1'b1};
                bit_ff <= bit_ff + 4'h1;
              end
            endcase
          end
          if (byte_end) begin
            bit_ff <= 4'h0;
            state_ff <= smb_pkg::H_STOP;
            if (step_ff == smb_pkg::S_READ) begin
              rd_data_ff <= rx_ff[8:1];
            end else if (got_nack) begin
              nack_ff <= 1'b1;
            end else if (step_ff == smb_pkg::S_ADDRW) begin
              step_ff <= smb_pkg::S_PTR;
              tx_ff <= {ptr_ff, 1'b1};
              state_ff <= smb_pkg::H_BIT;
            end else if (step_ff == smb_pkg::S_ADDRR) begin
              step_ff <= smb_pkg::S_READ;
              tx_ff <= 9'h1ff;
              state_ff <= smb_pkg::H_BIT;
            end else if (step_ff == smb_pkg::S_PTR && kind_ff == smb_pkg::C_WRITE) begin
              step_ff <= smb_pkg::S_DATA;
              tx_ff <= {data_ff, 1'b1};
              state_ff <= smb_pkg::H_BIT;
            end else if (step_ff == smb_pkg::S_PTR && kind_ff == smb_pkg::C_READ_BYTE) begin
              step_ff <= smb_pkg::S_ADDRR;
              tx_ff <= {addr_ff, `SMB_DIR_READ, 1'b1};
              state_ff <= smb_pkg::H_START;
            end
          end
        end
        smb_pkg::H_STOP: begin
          if (tick) begin
            phase_ff <= phase_ff + 2'h1;
            case (phase_ff)
              2'h0: sda_oe_ff <= 1'b1;
              2'h1: scl_oe_ff <= 1'b0;
              2'h2: sda_oe_ff <= 1'b0;
              default: begin
                done_ff <= 1'b1;
                cmd_ready_ff <= 1'b1;
                state_ff <= smb_pkg::H_IDLE;
              end
            endcase
          end
        end
        default: state_ff <= smb_pkg::H_IDLE;
      endcase
    end
  end

  assign bus.scl_host_o = zero_ff;
  assign bus.scl_host_oe = scl_oe_ff;
  assign bus.sda_host_o = zero_ff;
  assign bus.sda_host_oe = sda_oe_ff;
endmodule : smb_host

/* File: verif/smb_port_sva.sv */
// Purpose: wire checks on the two-wire register port
// Assumes: one host and one device share the bus
// Notes: helper logic counts clock rises from each start
`timescale 1ns/10ps
`include "smb_defines.svh"
module smb_port_sva (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_dev_oe
);
  logic scl_d_ff, sda_d_ff, rd_dir_ff, acked_ff;
  logic [7:0] cnt_ff, addr_ff;
  wire rise = scl & ~scl_d_ff;
  wire start_c = scl & scl_d_ff & sda_d_ff & ~sda;
  wire [7:0] nxt_cnt = rise ? cnt_ff + 8'h01 : cnt_ff;
  wire [7:0] slot_now = nxt_cnt % 8'h09;
  wire [7:0] idx_now = (nxt_cnt - 8'h01) / 8'h09;
  wire [7:0] slot_ff = cnt_ff % 8'h09;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
      cnt_ff <= 8'h00;
      addr_ff <= 8'h00;
      rd_dir_ff <= 1'b0;
      acked_ff <= 1'b0;
    end else begin
      scl_d_ff <= scl;
      sda_d_ff <= sda;
      if (start_c) begin
        cnt_ff <= 8'h00;
        rd_dir_ff <= 1'b0;
        acked_ff <= 1'b0;
      end else if (rise) begin
        cnt_ff <= nxt_cnt;
        if (nxt_cnt <= 8'h08) addr_ff <= {addr_ff[6:0], sda};
        if (nxt_cnt == 8'h08) rd_dir_ff <= sda;
        if (nxt_cnt == 8'h09) acked_ff <= sda_dev_oe;
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  AST_OE_RISE_SCL_LOW: assert property ($rose(sda_dev_oe) |-> !scl)
    else $error("device began driving data while clock high");
  AST_OE_FALL_SCL_LOW: assert property ($fell(sda_dev_oe) |-> !scl)
    else $error("device released data while clock high");
  AST_DRIVE_WINDOW: assert property (scl && sda_dev_oe |-> slot_now == 8'h00 || (rd_dir_ff && idx_now == 8'h01))
    else $error("device drove data outside ack or read slot");
  AST_ADDR_MATCH: assert property (scl && sda_dev_oe && nxt_cnt == 8'h09 |->
    addr_ff[7:1] inside {`SMB_ADDR_FIXED, `SMB_ADDR_SEL_LOW, `SMB_ADDR_SEL_HIGH})
    else $error("device acknowledged a foreign address");
  AST_BYTE_LIMIT: assert property (scl && sda_dev_oe |-> idx_now <= (rd_dir_ff ? 8'h01 : 8'h02))
    else $error("device drove beyond its byte count");
  AST_DIR_HELD: assert property (scl && sda_dev_oe && idx_now >= 8'h01 && slot_now != 8'h00 |-> rd_dir_ff)
    else $error("device sent data in a write operation");
  AST_WRITE_ACK_DUE: assert property ($fell(scl) && cnt_ff inside {8'h11, 8'h1a} && acked_ff && !rd_dir_ff
    |-> ##[1:8] sda_dev_oe)
    else $error("device did not acknowledge a write byte");
  AST_ACK_RELEASE: assert property ($fell(scl) && slot_ff == 8'h00 && cnt_ff != 8'h00 && !rd_dir_ff && sda_dev_oe
    |-> ##[1:8] !sda_dev_oe)
    else $error("device held ack past its slot");
  AST_RESTART_IDLE: assert property (start_c |-> !sda_dev_oe)
    else $error("device drove data at a start");
endmodule : smb_port_sva

/* File: verif/smbus_slave_register_port_bench.sv */
// Purpose: runs both ends of the register port against each other
// Assumes: short quarter period and timeout for simulation
// Notes: the bench holds the register file behind the device
`timescale 1ns/10ps
module smbus_slave_register_port_bench;
  logic clk, reset_n, address_strap_enable, address_strap_select, cmd_valid;
  smb_pkg::smb_cmd_t cmd_kind;
  logic [6:0] cmd_addr, bus_addr;
  logic [7:0] cmd_ptr, cmd_data, rd_data, reg_index, wr_data, host_rd, sb, mon_first, last_first;
  logic wr_valid, addr_locked, cmd_ready, done, nack, mon_r18, last_r18;
  logic [7:0] regs [0:255];
  logic [6:0] adr [0:2] = '{7'h2c, 7'h2d, 7'h2e};
  logic ens [0:2] = '{1'b0, 1'b0, 1'b1};
  logic sels [0:2] = '{1'b0, 1'b1, 1'b0};
  int failures, n_compared, mon_rises, last_rises;
  smb_if smb_bus();
  smb_dev #(.TIMEOUT_CYC(2000)) smb_dev_inst (.clk(clk), .reset_n(reset_n), .bus(smb_bus.dev),
    .address_strap_enable(address_strap_enable), .address_strap_select(address_strap_select),
    .bus_timeout_disable(1'b0), .rd_data(rd_data), .reg_index_ff(reg_index), .wr_valid_ff(wr_valid),
    .wr_data_ff(wr_data), .bus_addr_ff(bus_addr), .addr_locked_ff(addr_locked));
  smb_host #(.QTR_CYC(10)) smb_host_inst (.clk(clk), .reset_n(reset_n), .bus(smb_bus.host),
    .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_addr(cmd_addr), .cmd_ptr(cmd_ptr), .cmd_data(cmd_data),
    .cmd_ready_ff(cmd_ready), .done_ff(done), .nack_ff(nack), .rd_data_ff(host_rd));
  smb_port_sva smb_port_sva_inst (.clk(clk), .reset_n(reset_n), .scl(smb_bus.scl), .sda(smb_bus.sda),
    .sda_dev_oe(smb_bus.sda_dev_oe));
  assign rd_data = regs[reg_index];
  always @(posedge clk) begin
    if (wr_valid === 1'b1) regs[reg_index] <= wr_data;
  end
  // wire monitor: rises since start, first byte, bit at rise 18
  always @(posedge smb_bus.scl) begin
    mon_rises++;
    if (mon_rises <= 8) mon_first = {mon_first[6:0], smb_bus.sda};
    if (mon_rises == 18) mon_r18 = smb_bus.sda;
  end
  always @(negedge smb_bus.sda) begin
    if (smb_bus.scl === 1'b1) mon_rises = 0;
  end
  always @(posedge smb_bus.sda) begin
    if (smb_bus.scl === 1'b1) begin
      last_rises = mon_rises;
      last_first = mon_first;
      last_r18 = mon_r18;
    end
  end
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  task automatic run(input smb_pkg::smb_cmd_t k, input logic [6:0] a, input logic [7:0] p, input logic [7:0] d);
    int i;
    for (i = 0; i < 100 && cmd_ready !== 1'b1; i++) @(posedge clk);
    if (cmd_ready !== 1'b1) begin
      failures++;
      conclude();
    end
    cmd_kind <= k;
    cmd_addr <= a;
    cmd_ptr <= p;
    cmd_data <= d;
    cmd_valid <= 1'b1;
    @(posedge clk);
    cmd_valid <= 1'b0;
    @(posedge clk);
    for (i = 0; i < 5000 && done !== 1'b1; i++) @(posedge clk);
    if (done !== 1'b1) begin
      failures++;
      conclude();
    end
  endtask : run
  task automatic xfer(input smb_pkg::smb_cmd_t k, input logic [6:0] a, input logic [7:0] p, input logic [7:0] d,
                      input logic exp_nack, input logic [7:0] exp_rd);
    logic rd;
    rd = (k == smb_pkg::C_RECEIVE || k == smb_pkg::C_READ_BYTE);
    run(k, a, p, d);
    chk("nack", {7'h00, exp_nack}, {7'h00, nack});
    chk("clock rises", exp_nack ? 8'h0a : (k == smb_pkg::C_WRITE ? 8'h1c : 8'h13), last_rises[7:0]);
    chk("address byte", {a, rd}, last_first);
    if (rd && !exp_nack) begin
      chk("read data", exp_rd, host_rd);
      chk("read ack bit", 8'h01, {7'h00, last_r18});
    end
  endtask : xfer
  initial begin
    failures = 0;
    n_compared = 0;
    mon_rises = 0;
    last_rises = 0;
    mon_first = 8'h00;
    last_first = 8'h00;
    mon_r18 = 1'b0;
    last_r18 = 1'b0;
    reset_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_kind = smb_pkg::C_SEND_PTR;
    cmd_addr = 7'h00;
    cmd_ptr = 8'h00;
    cmd_data = 8'h00;
    address_strap_enable = 1'b0;
    address_strap_select = 1'b0;
    for (int i = 0; i < 256; i++) regs[i] = 8'(i) ^ 8'h5a;
    for (int s = 0; s < 3; s++) begin
      sb = 8'(s);
      @(posedge clk);
      address_strap_enable <= ens[s];
      address_strap_select <= sels[s];
      reset_n <= 1'b0;
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      repeat (8) @(posedge clk);
      xfer(smb_pkg::C_SEND_PTR, adr[(s + 1) % 3], 8'h33, 8'h00, 1'b1, 8'h00);
      chk("locked", 8'h00, {7'h00, addr_locked});
      xfer(smb_pkg::C_WRITE, adr[s], 8'h10 + sb, 8'ha0 + sb, 1'b0, 8'h00);
      chk("register", 8'ha0 + sb, regs[8'h10 + sb]);
      chk("locked", 8'h01, {7'h00, addr_locked});
      chk("bus address", {1'b0, adr[s]}, {1'b0, bus_addr});
      address_strap_enable <= ~ens[s];
      address_strap_select <= ~sels[s];
      xfer(smb_pkg::C_SEND_PTR, adr[s], 8'h40, 8'h00, 1'b0, 8'h00);
      chk("pointer", 8'h40, reg_index);
      chk("register", 8'h1a, regs[8'h40]);
      xfer(smb_pkg::C_RECEIVE, adr[s], 8'h00, 8'h00, 1'b0, 8'h1a);
      xfer(smb_pkg::C_READ_BYTE, adr[s], 8'h10 + sb, 8'h00, 1'b0, 8'ha0 + sb);
      xfer(smb_pkg::C_RECEIVE, adr[s], 8'h00, 8'h00, 1'b0, 8'ha0 + sb);
      $display("test with strap set %0d finished", s);
    end
    conclude();
  end
endmodule : smbus_slave_register_port_bench
